/* File: twe_consts.vh */
// Register offsets, field positions and reset values of the event logic.
`ifndef TWE_CONSTS_VH
`define TWE_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define TWE_OFF_HALTED    12'h104
`define TWE_OFF_RXBYTE    12'h108
`define TWE_OFF_TXDONE    12'h11C
`define TWE_OFF_FAULT     12'h124
`define TWE_OFF_BOUNDARY  12'h138
`define TWE_OFF_PAUSED    12'h148
`define TWE_OFF_LINKS     12'h200
`define TWE_OFF_IRQ_SET   12'h304
`define TWE_OFF_IRQ_CLR   12'h308
`define TWE_OFF_EV_STATUS 12'h400
`define TWE_OFF_RX_DATA   12'h408
`define TWE_OFF_FAULT_SRC 12'h4C4

// ****************************************
// Event bit positions
// ****************************************
`define TWE_EV_HALTED   0
`define TWE_EV_RXBYTE   1
`define TWE_EV_TXDONE   2
`define TWE_EV_FAULT    3
`define TWE_EV_BOUNDARY 4
`define TWE_EV_PAUSED   5
`define TWE_EV_W        6

// ****************************************
// Link and fault source bit positions
// ****************************************
`define TWE_LINK_PAUSE  0
`define TWE_LINK_HALT   1
`define TWE_FS_OVERRUN  0
`define TWE_FS_ADDR_NAK 1
`define TWE_FS_DATA_NAK 2

// ****************************************
// Reset values and counts
// ****************************************
`define TWE_RST_EVENTS  6'h00
`define TWE_RST_LINKS   2'h0
`define TWE_RST_IRQ_EN  6'h00
`define TWE_RST_FAULTS  3'h0
`define TWE_ACK_BIT     4'h8
`define TWE_RW_BIT      4'h7

`endif

/* File: twe_sync.v */
// Two-flop synchroniser for a pin, with edge pulses taken from the safe stage.
`timescale 1ns/1ps
module twe_sync (
  input  wire clk,    // system clock
  input  wire reset,  // asynchronous reset, active high
  input  wire pin,    // asynchronous pin level
  input  wire init,   // enable of the rise and fall pulses
  output wire level,  // synchronised level
  output wire rise,   // one-cycle pulse on a rising edge
  output wire fall    // one-cycle pulse on a falling edge
);
  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg & init;
  assign fall  = ~sync_reg & prev_reg & init;
endmodule

/* File: twe_event_logic.v */
// Event flags, shortcuts and interrupt enables of a two-wire master.
// Function
// - Set the received-byte flag when a byte has been received.
// - Set the transmitted-byte flag once a byte has been sent.
// - Raise byte-boundary event before every byte sent or received.
// - Raise paused event after read acknowledge, only if pause was requested.
// - Boundary-to-pause link set: each boundary event triggers the pause task.
// - Boundary-to-halt link triggers halt task; links reset to zero.
// - Writing one to enable-set enables that interrupt; zeros ignored; reads state.
// - Writing one to enable-clear disables that interrupt; reads same state.
// - Address not acknowledged flags a fault source and raises the fault event.
// - Byte arriving before previous byte was read flags overrun; old byte lost.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "twe_consts.vh"
module twe_event_logic #(
  parameter ADDR_W = 12  // register address width
) (
  input  wire              clk,         // 20 MHz system clock
  input  wire              reset,       // asynchronous reset, active high
  input  wire [ADDR_W-1:0] addr,        // register byte address
  input  wire [31:0]       wdata,       // register write data
  input  wire              wr,          // write strobe
  input  wire              rd,          // read strobe
  output reg  [31:0]       rdata,       // read data, one cycle after rd
  input  wire              scl_in,      // two-wire clock pin level
  input  wire              sda_in,      // two-wire data pin level
  input  wire              pause_task,  // pause request pulse from task logic
  output reg               pause_req,   // pause task pulse to the bus engine
  output reg               halt_req,    // halt task pulse to the bus engine
  output wire              irq          // interrupt, active high level
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire scl_lvl;
  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;

  // Both pins pass identical chains, so their relative order survives the crossing.
  twe_sync u_scl (
    .clk   (clk),
    .reset (reset),
    .pin   (scl_in),
    .init  (1'b1),
    .level (scl_lvl),
    .rise  (scl_rise),
    .fall  (scl_fall)
  );

  twe_sync u_sda (
    .clk   (clk),
    .reset (reset),
    .pin   (sda_in),
    .init  (1'b1),
    .level (sda_lvl),
    .rise  (sda_rise),
    .fall  (sda_fall)
  );

  // Start and stop are data edges while the clock stays high.
  wire start_cond = sda_fall & scl_lvl & ~scl_fall;
  wire stop_cond  = sda_rise & scl_lvl & ~scl_fall;

  // ****************************************
  // Bus monitor
  // ****************************************
  localparam ST_IDLE   = 1'b0;
  localparam ST_ACTIVE = 1'b1;

  reg       state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg       first_reg;
  reg       read_reg;
  reg       ack_done_reg;
  reg       pause_pend_reg;

  reg ev_halted;
  reg ev_rx;
  reg ev_tx;
  reg ev_bound;
  reg ev_paused;
  reg fs_addr;
  reg fs_data;
  reg fs_over;
  reg rx_full_reg;
  reg [7:0] rx_data_reg;

  // A read of the data register in the same cycle as a new byte counts as read in time.
  wire rx_take = rd && (addr == `TWE_OFF_RX_DATA);

  // Event pulses for this cycle; the ninth rising clock edge of a byte is the acknowledge.
  always @* begin
    ev_halted = 1'b0;
    ev_rx     = 1'b0;
    ev_tx     = 1'b0;
    ev_bound  = 1'b0;
    ev_paused = 1'b0;
    fs_addr   = 1'b0;
    fs_data   = 1'b0;
    fs_over   = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        ev_bound = start_cond;
      end
      ST_ACTIVE: begin
        if (stop_cond) begin
          ev_halted = 1'b1;
        end else if (start_cond) begin
          ev_bound = 1'b1;
        end else if (scl_rise && bit_cnt_reg == `TWE_ACK_BIT) begin
          if (first_reg) begin
            fs_addr = sda_lvl;
          end else if (read_reg) begin
            ev_rx   = 1'b1;
            fs_over = rx_full_reg & ~rx_take;
          end else begin
            ev_tx   = 1'b1;
            fs_data = sda_lvl;
          end
        end else if (scl_fall && ack_done_reg) begin
          ev_bound  = 1'b1;
          ev_paused = read_reg & ~first_reg & pause_pend_reg;
        end
      end
      default: begin
        ev_bound = 1'b0;
      end
    endcase
  end

  // A stop ends the frame in any state; a start, first or repeated, opens a new one.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      first_reg    <= 1'b0;
      read_reg     <= 1'b0;
      ack_done_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg    <= ST_IDLE;
      ack_done_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg    <= ST_ACTIVE;
      bit_cnt_reg  <= 4'h0;
      first_reg    <= 1'b1;
      read_reg     <= 1'b0;
      ack_done_reg <= 1'b0;
    end else if (state_reg == ST_ACTIVE) begin
      if (scl_rise) begin
        if (bit_cnt_reg == `TWE_ACK_BIT) begin
          bit_cnt_reg  <= 4'h0;
          ack_done_reg <= 1'b1;
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          shift_reg   <= {shift_reg[6:0], sda_lvl};
          if (first_reg && bit_cnt_reg == `TWE_RW_BIT) begin
            read_reg <= sda_lvl;
          end
        end
      end else if (scl_fall && ack_done_reg) begin
        ack_done_reg <= 1'b0;
        first_reg    <= 1'b0;
      end
    end
  end

  // ****************************************
  // Receive holding register
  // ****************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_full_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end else if (ev_rx) begin
      rx_full_reg <= 1'b1;
      rx_data_reg <= shift_reg;
    end else if (rx_take) begin
      rx_full_reg <= 1'b0;
    end
  end

  // ****************************************
  // Shortcuts and task requests
  // ****************************************
  reg [1:0] links_reg;

  // A pause request arms the paused event; the next read acknowledge or a stop disarms it.

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pause_req      <= 1'b0;
      halt_req       <= 1'b0;
      pause_pend_reg <= 1'b0;
    end else begin
      pause_req <= pause_task | (ev_bound & links_reg[`TWE_LINK_PAUSE]);
      halt_req  <= ev_bound & links_reg[`TWE_LINK_HALT];
      if (pause_req) begin
        pause_pend_reg <= 1'b1;
      end else if (ev_paused || ev_halted) begin
        pause_pend_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  reg  [`TWE_EV_W-1:0] events_reg;
  reg  [`TWE_EV_W-1:0] events_next;
  reg  [`TWE_EV_W-1:0] irq_en_reg;
  reg  [`TWE_EV_W-1:0] irq_en_next;
  reg  [2:0]           faults_reg;
  reg  [2:0]           faults_next;
  wire [`TWE_EV_W-1:0] ev_set;
  wire [2:0]           fs_set;
  wire [`TWE_EV_W-1:0] wr_ev_bits;
  wire [2:0]           wr_fs_bits;

  // One hit line per register that software may write.
  wire hit_halted   = wr && (addr == `TWE_OFF_HALTED);
  wire hit_rxbyte   = wr && (addr == `TWE_OFF_RXBYTE);
  wire hit_txdone   = wr && (addr == `TWE_OFF_TXDONE);
  wire hit_fault    = wr && (addr == `TWE_OFF_FAULT);
  wire hit_boundary = wr && (addr == `TWE_OFF_BOUNDARY);
  wire hit_paused   = wr && (addr == `TWE_OFF_PAUSED);
  wire hit_status   = wr && (addr == `TWE_OFF_EV_STATUS);
  wire hit_fsrc     = wr && (addr == `TWE_OFF_FAULT_SRC);
  wire hit_links    = wr && (addr == `TWE_OFF_LINKS);
  wire hit_irq_set  = wr && (addr == `TWE_OFF_IRQ_SET);
  wire hit_irq_clr  = wr && (addr == `TWE_OFF_IRQ_CLR);

  assign wr_ev_bits = wdata[`TWE_EV_W-1:0];
  assign wr_fs_bits = wdata[2:0];
  assign fs_set     = {fs_data, fs_addr, fs_over};
  assign ev_set     = {ev_paused, ev_bound, |fs_set, ev_tx, ev_rx, ev_halted};

  // A single event register takes bit 0 as written, the status register clears by ones.
  // A hardware event in the same cycle as a clear wins, so no event is lost.
  always @* begin
    events_next = events_reg;
    if (hit_halted) begin
      events_next[`TWE_EV_HALTED] = wdata[0];
    end
    if (hit_rxbyte) begin
      events_next[`TWE_EV_RXBYTE] = wdata[0];
    end
    if (hit_txdone) begin
      events_next[`TWE_EV_TXDONE] = wdata[0];
    end
    if (hit_fault) begin
      events_next[`TWE_EV_FAULT] = wdata[0];
    end
    if (hit_boundary) begin
      events_next[`TWE_EV_BOUNDARY] = wdata[0];
    end
    if (hit_paused) begin
      events_next[`TWE_EV_PAUSED] = wdata[0];
    end
    if (hit_status) begin
      events_next = events_reg & ~wr_ev_bits;
    end
    events_next = events_next | ev_set;
  end

  // Fault source bits clear by ones and are set again by any new fault.
  always @* begin
    faults_next = faults_reg;
    if (hit_fsrc) begin
      faults_next = faults_reg & ~wr_fs_bits;
    end
    faults_next = faults_next | fs_set;
  end

  // Set and clear share one enable register, so both read back the same state.
  always @* begin
    irq_en_next = irq_en_reg;
    if (hit_irq_set) begin
      irq_en_next = irq_en_reg | wr_ev_bits;
    end else if (hit_irq_clr) begin
      irq_en_next = irq_en_reg & ~wr_ev_bits;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      events_reg <= `TWE_RST_EVENTS;
      faults_reg <= `TWE_RST_FAULTS;
      links_reg  <= `TWE_RST_LINKS;
      irq_en_reg <= `TWE_RST_IRQ_EN;
    end else begin
      events_reg <= events_next;
      faults_reg <= faults_next;
      irq_en_reg <= irq_en_next;
      if (hit_links) begin
        links_reg <= wdata[1:0];
      end
    end
  end

  assign irq = |(events_reg & irq_en_reg);

  // ****************************************
  // Read path
  // ****************************************
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr)
      `TWE_OFF_HALTED:    rd_mux[0] = events_reg[`TWE_EV_HALTED];
      `TWE_OFF_RXBYTE:    rd_mux[0] = events_reg[`TWE_EV_RXBYTE];
      `TWE_OFF_TXDONE:    rd_mux[0] = events_reg[`TWE_EV_TXDONE];
      `TWE_OFF_FAULT:     rd_mux[0] = events_reg[`TWE_EV_FAULT];
      `TWE_OFF_BOUNDARY:  rd_mux[0] = events_reg[`TWE_EV_BOUNDARY];
      `TWE_OFF_PAUSED:    rd_mux[0] = events_reg[`TWE_EV_PAUSED];
      `TWE_OFF_LINKS:     rd_mux[1:0] = links_reg;
      `TWE_OFF_IRQ_SET:   rd_mux[`TWE_EV_W-1:0] = irq_en_reg;
      `TWE_OFF_IRQ_CLR:   rd_mux[`TWE_EV_W-1:0] = irq_en_reg;
      `TWE_OFF_EV_STATUS: rd_mux[`TWE_EV_W-1:0] = events_reg;
      `TWE_OFF_RX_DATA:   rd_mux[7:0] = rx_data_reg;
      `TWE_OFF_FAULT_SRC: rd_mux[2:0] = faults_reg;
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stand in the one cycle after the strobe and are zero otherwise.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule

/* File: twe_event_monitor.sv */
// Concurrent checks on the ports of the two-wire event logic.
`timescale 1ns/1ps
`include "twe_consts.vh"
module twe_event_monitor #(
  parameter ADDR_W = 12  // register address width
) (
  input wire              clk,         // system clock
  input wire              reset,       // asynchronous reset, active high
  input wire [ADDR_W-1:0] addr,        // register byte address
  input wire [31:0]       wdata,       // register write data
  input wire              wr,          // write strobe
  input wire              rd,          // read strobe
  input wire [31:0]       rdata,       // read data
  input wire              scl_in,      // clock pin level
  input wire              sda_in,      // data pin level
  input wire              pause_task,  // pause request pulse
  input wire              pause_req,   // pause task pulse
  input wire              halt_req,    // halt task pulse
  input wire              irq          // interrupt level
);
  // ****************************************
  // Shadows of what software wrote
  // ****************************************
  logic [5:0] en_mdl;
  logic [1:0] lk_mdl;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      en_mdl <= 6'h00;
      lk_mdl <= 2'h0;
    end else if (wr) begin
      if (addr == `TWE_OFF_IRQ_SET) en_mdl <= en_mdl | wdata[5:0];
      if (addr == `TWE_OFF_IRQ_CLR) en_mdl <= en_mdl & ~wdata[5:0];
      if (addr == `TWE_OFF_LINKS) lk_mdl <= wdata[1:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_enable_read: assert property (rd && (addr == `TWE_OFF_IRQ_SET ||
    addr == `TWE_OFF_IRQ_CLR) |=> rdata == {26'h0, $past(en_mdl)})
    else $error("enable readback differs from written enables");
  a_links_read: assert property (rd && addr == `TWE_OFF_LINKS |=>
    rdata == {30'h0, $past(lk_mdl)}) else $error("link readback wrong");
  a_irq_masked: assert property (en_mdl == 6'h00 |-> !irq)
    else $error("interrupt high with all enables off");
  a_pause_cause: assert property (pause_req |-> $past(pause_task) || $past(lk_mdl[0]))
    else $error("pause pulse without request or link");
  a_halt_cause: assert property (halt_req |-> $past(lk_mdl[1]))
    else $error("halt pulse with halt link off");
  a_task_follow: assert property (pause_task |=> pause_req)
    else $error("pause request not passed on");
  a_halt_single: assert property (halt_req |=> !halt_req)
    else $error("halt pulse longer than one cycle");
  a_links_both: assert property (halt_req && $past(lk_mdl) == 2'h3 |-> pause_req)
    else $error("boundary did not fire both links");

  c_link_pause: cover property (pause_req && !$past(pause_task));
  c_halt: cover property (halt_req);
  c_irq: cover property ($rose(irq));
endmodule

bind twe_event_logic twe_event_monitor #(.ADDR_W(ADDR_W)) mon_u (.clk(clk), .reset(reset),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_in),
  .sda_in(sda_in), .pause_task(pause_task), .pause_req(pause_req), .halt_req(halt_req),
  .irq(irq));

/* File: twe_wire_model.sv */
// Behavioural two-wire bus traffic as seen at the pins of the event logic.
`timescale 1ns/1ps
module twe_wire_model (
  output logic scl,  // clock line, pulled up
  output logic sda   // data line, pulled up
);
  localparam int HALF = 200;

  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end

  // The odd offset keeps line changes clear of the system clock edges.
  task start();
    #13;
    sda = 1'h0;
    #HALF;
    scl = 1'h0;
    #(HALF / 4);
  endtask

  task put_bit(input logic b);
    sda = b;
    #HALF;
    scl = 1'h1;
    #HALF;
    scl = 1'h0;
    #(HALF / 4);
  endtask

  // Bytes go most significant bit first, then the acknowledge bit.
  task put_byte(input logic [7:0] b, input logic ack);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    put_bit(ack);
  endtask

  task stop();
    sda = 1'h0;
    #HALF;
    scl = 1'h1;
    #HALF;
    sda = 1'h1;
    #(2 * HALF);
  endtask
endmodule

/* File: i2c_master_event_shortcut_logic_bench.sv */
// Self-checking bench for the two-wire event, shortcut and interrupt logic.
`timescale 1ns/1ps
module i2c_master_event_shortcut_logic_bench;
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic        pause_task = 1'h0;
  logic [31:0] rdata;
  logic        scl;
  logic        sda;
  logic        pause_req;
  logic        halt_req;
  logic        irq;
  int          failures = 0;
  int          checks = 0;
  int          n_pause = 0;
  int          n_halt = 0;
  // Each row holds address, write flag, write data and the expected read value.
  logic [28:0] rows [0:18] = '{
    {12'h104, 1'h0, 8'h00, 8'h00}, {12'h108, 1'h0, 8'h00, 8'h00}, {12'h11C, 1'h0, 8'h00, 8'h00},
    {12'h124, 1'h0, 8'h00, 8'h00}, {12'h138, 1'h0, 8'h00, 8'h00}, {12'h148, 1'h0, 8'h00, 8'h00},
    {12'h200, 1'h0, 8'h00, 8'h00}, {12'h304, 1'h0, 8'h00, 8'h00}, {12'h308, 1'h0, 8'h00, 8'h00},
    {12'h0FC, 1'h0, 8'h00, 8'h00}, {12'h200, 1'h1, 8'h03, 8'h03}, {12'h200, 1'h1, 8'h00, 8'h00},
    {12'h304, 1'h1, 8'h21, 8'h21}, {12'h304, 1'h1, 8'h00, 8'h21}, {12'h308, 1'h1, 8'h01, 8'h20},
    {12'h308, 1'h1, 8'h20, 8'h00}, {12'h0FC, 1'h1, 8'hFF, 8'h00}, {12'h104, 1'h1, 8'h01, 8'h01},
    {12'h104, 1'h1, 8'h00, 8'h00}};

  always #25 clk = ~clk;

  twe_event_logic dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .scl_in(scl), .sda_in(sda), .pause_task(pause_task),
    .pause_req(pause_req), .halt_req(halt_req), .irq(irq));
  twe_wire_model wm_u (.scl(scl), .sda(sda));

  always @(posedge clk) begin
    if (pause_req === 1'h1) n_pause <= n_pause + 1;
    if (halt_req === 1'h1) n_halt <= n_halt + 1;
  end

  // ****************************************
  // Bus cycles and comparison
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    chk(rdata, e);
  endtask

  task frame(input logic [7:0] a, input logic na, input int n, input logic [7:0] d0, d1);
    wm_u.start();
    wm_u.put_byte(a, na);
    if (n > 0) wm_u.put_byte(d0, 1'h0);
    if (n > 1) wm_u.put_byte(d1, 1'h0);
    wm_u.stop();
  endtask

  task give_verdict();
    $display("Checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #1_000_000;
    failures++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    foreach (rows[i]) begin
      if (rows[i][16]) wr_reg(rows[i][28:17], {24'h00_0000, rows[i][15:8]});
      rd_chk(rows[i][28:17], {24'h00_0000, rows[i][7:0]});
    end
    // Both links on: each boundary of a one-byte frame fires pause and halt.
    wr_reg(12'h304, 32'h0000_0010);
    wr_reg(12'h200, 32'h0000_0003);
    frame(8'h54, 1'h0, 0, 8'h00, 8'h00);
    chk(n_pause, 32'h0000_0002);
    chk(n_halt, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0001);
    rd_chk(12'h138, 32'h0000_0001);
    wr_reg(12'h200, 32'h0000_0000);
    wr_reg(12'h400, 32'h0000_003F);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    // A pause request before a read frame; links are off now.
    @(posedge clk);
    pause_task <= 1'h1;
    @(posedge clk);
    pause_task <= 1'h0;
    frame(8'h55, 1'h0, 1, 8'hC3, 8'h00);
    chk(n_pause, 32'h0000_0003);
    chk(n_halt, 32'h0000_0002);
    rd_chk(12'h148, 32'h0000_0001);
    rd_chk(12'h108, 32'h0000_0001);
    rd_chk(12'h408, 32'h0000_00C3);
    rd_chk(12'h104, 32'h0000_0001);
    // Two unread bytes: overrun, and no pause without a new request.
    wr_reg(12'h400, 32'h0000_003F);
    frame(8'h55, 1'h0, 2, 8'h3C, 8'hA5);
    rd_chk(12'h148, 32'h0000_0000);
    rd_chk(12'h4C4, 32'h0000_0001);
    rd_chk(12'h124, 32'h0000_0001);
    rd_chk(12'h408, 32'h0000_00A5);
    wr_reg(12'h4C4, 32'h0000_0007);
    wr_reg(12'h400, 32'h0000_003F);
    frame(8'h54, 1'h0, 1, 8'h5A, 8'h00);
    rd_chk(12'h11C, 32'h0000_0001);
    rd_chk(12'h124, 32'h0000_0000);
    frame(8'h54, 1'h1, 0, 8'h00, 8'h00);
    rd_chk(12'h124, 32'h0000_0001);
    rd_chk(12'h4C4, 32'h0000_0002);
    // A reset in mid-run returns the enables to zero.
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    rd_chk(12'h304, 32'h0000_0000);
    give_verdict();
  end
endmodule
